//--- hw/socket_status_force_regs.sv
// Overview of operation
// - bit 6 shows live ready/irq pin level
// - bit 5 wide-bus card, set by interrogation
// - bit 4 narrow card, set by interrogation
// - bit 3 shows socket powered up or down
// - bit 2 follows detect b, frozen while probing
// - bit 1 follows detect a, frozen while probing
// - bit 0 shows live status-change pin level
// - force bits 31..15 and 6 read zero
// - bit 14 reinterrogates, refreshes, reenables power control
// - force bits 13..10 load voltage support bits
// - any force voltage one disables power control
// - force bit 9 loads bad supply request
// - force bits 8,7,5,4 load matching state bits
// - force bits 3..0 load event register bits
// - forcing events leaves live state bits alone
// - voltage and type bits change only on interrogation or a force
`timescale 1ns/10ps

module socket_status_force_regs (
   input  wire logic                                clk_sys_in,
   input  wire logic                                rst_b_in,
   input  wire logic [7:0]                          reg_addr_in,
   input  wire logic [31:0]                         reg_wdata_in,
   input  wire logic                                reg_wr_in,
   input  wire logic                                reg_rd_in,
   output logic      [31:0]                         reg_rdata_out,
   input  wire socket_status_force_pkg::socket_pins_s pins_in,
   input  wire socket_status_force_pkg::card_id_s   card_id_in,
   input  wire logic                                power_good_in,
   input  wire logic                                bad_supply_req_in,
   input  wire logic                                data_loss_in,
   output logic                                     power_ctrl_en_out,
   output logic                                     interrogating_out,
   output logic                                     irq_out
);

   localparam int SYNC_W = 12;
   // detect stages start at the empty-slot level, so leaving
   // reset can never look like an insertion
   localparam logic [SYNC_W-1:0] SYNC_RST = 12'h600;

   // pin synchroniser stages
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;

   // synchronised views
   socket_status_force_pkg::socket_pins_s pins_s;
   socket_status_force_pkg::card_id_s     id_s;
   logic                                  pgood_s;

   // sequencer
   socket_status_force_pkg::interrog_e state_q;
   socket_status_force_pkg::interrog_e state_d;
   logic [7:0]                         cnt_q;
   logic [7:0]                         cnt_d;

   // held state
   socket_status_force_pkg::card_id_s card_q;
   socket_status_force_pkg::card_id_s card_d;
   logic                              bad_q;
   logic                              bad_d;
   logic                              loss_q;
   logic                              loss_d;
   logic                              det_a_q;
   logic                              det_a_d;
   logic                              det_b_q;
   logic                              det_b_d;
   logic                              stat_q;
   logic                              pwr_q;
   logic                              pwr_en_q;
   logic                              pwr_en_d;

   // event and mask
   logic [3:0] event_q;
   logic [3:0] event_d;
   logic [3:0] mask_q;
   logic [3:0] mask_d;
   logic [3:0] event_set;

   // bus
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [31:0] state_word;

   // decode
   wire hit_event = (reg_addr_in == socket_status_force_pkg::EVENT_OFS);
   wire hit_mask  = (reg_addr_in == socket_status_force_pkg::MASK_OFS);
   wire hit_state = (reg_addr_in == socket_status_force_pkg::STATE_OFS);
   wire hit_force = (reg_addr_in == socket_status_force_pkg::FORCE_OFS);
   wire wr_event  = reg_wr_in & hit_event;
   wire wr_mask   = reg_wr_in & hit_mask;
   wire wr_force  = reg_wr_in & hit_force;

   // force word fields
   wire [3:0] f_volt    = reg_wdata_in[13:10];
   wire       f_bad     =
      reg_wdata_in[socket_status_force_pkg::BAD_SUPPLY_BIT];
   wire       f_loss    = reg_wdata_in[socket_status_force_pkg::LOSS_BIT];
   wire       f_unknown = reg_wdata_in[socket_status_force_pkg::UNKNOWN_BIT];
   wire       f_wide    = reg_wdata_in[socket_status_force_pkg::WIDE_BIT];
   wire       f_narrow  = reg_wdata_in[socket_status_force_pkg::NARROW_BIT];
   wire [3:0] f_events  = reg_wdata_in[3:0];
   wire       f_reint   =
      reg_wdata_in[socket_status_force_pkg::REINTERROG_BIT];

   // synchronised fields, never from the first stage
   assign pins_s  = sync2_q[11:8];
   assign id_s    = sync2_q[7:1];
   assign pgood_s = sync2_q[0];

   // card pins and sense lines come from off chip
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
      end else begin
         sync1_q <= {pins_in, card_id_in, power_good_in};
         sync2_q <= sync1_q;
      end
   end

   // insertion seen when both detect pins go low outside a probe
   wire both_low  = ~pins_s.detect_a & ~pins_s.detect_b;
   wire was_out   = det_a_q | det_b_q;
   wire idle      = (state_q == socket_status_force_pkg::ST_IDLE);
   wire insert    = idle & both_low & was_out;
   wire reint_req = wr_force & f_reint;
   wire start     = insert | reint_req;
   wire cnt_done  =
      (cnt_q == 8'(socket_status_force_pkg::INTERROG_CYC - 1));
   wire latch     = (state_q == socket_status_force_pkg::ST_LATCH);

   // sequencer: a second trigger mid-probe restarts the wait
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         socket_status_force_pkg::ST_IDLE: begin
            if (start) begin
               state_d = socket_status_force_pkg::ST_PROBE;
               cnt_d   = '0;
            end
         end
         socket_status_force_pkg::ST_PROBE: begin
            if (reint_req) begin
               cnt_d = '0;
            end else if (cnt_done) begin
               state_d = socket_status_force_pkg::ST_LATCH;
            end else begin
               cnt_d = cnt_q + 8'h01;
            end
         end
         socket_status_force_pkg::ST_LATCH: begin
            if (reint_req) begin
               state_d = socket_status_force_pkg::ST_PROBE;
               cnt_d   = '0;
            end else begin
               state_d = socket_status_force_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = socket_status_force_pkg::ST_IDLE;
            cnt_d   = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q <= socket_status_force_pkg::ST_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // detect levels track the pins only outside a probe,
   // since the probe itself drives the detect lines
   always_comb begin
      det_a_d = det_a_q;
      det_b_d = det_b_q;
      if (idle) begin
         det_a_d = pins_s.detect_a;
         det_b_d = pins_s.detect_b;
      end
   end

   // identity: only interrogation or a force may change it
   always_comb begin
      card_d = card_q;
      if (latch) begin
         card_d = id_s;
      end
      if (wr_force) begin
         card_d.volt    = f_volt;
         card_d.unknown = f_unknown;
         card_d.wide    = f_wide;
         card_d.narrow  = f_narrow;
      end
   end

   // hardware reports win over a force in the same cycle
   always_comb begin
      bad_d  = bad_q;
      loss_d = loss_q;
      if (wr_force) begin
         bad_d  = f_bad;
         loss_d = f_loss;
      end
      if (bad_supply_req_in) begin
         bad_d = 1'b1;
      end
      if (data_loss_in) begin
         loss_d = 1'b1;
      end
   end

   // power control gate; a disabling force beats a re-enable
   always_comb begin
      pwr_en_d = pwr_en_q;
      if (latch) begin
         pwr_en_d = 1'b1;
      end
      if (wr_force & (|f_volt)) begin
         pwr_en_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         card_q   <= socket_status_force_pkg::CARD_ID_RESET;
         bad_q    <= 1'b0;
         loss_q   <= 1'b0;
         det_a_q  <= 1'b1;
         det_b_q  <= 1'b1;
         stat_q   <= 1'b0;
         pwr_q    <= 1'b0;
         pwr_en_q <= socket_status_force_pkg::PWR_EN_RST;
      end else begin
         card_q   <= card_d;
         bad_q    <= bad_d;
         loss_q   <= loss_d;
         det_a_q  <= det_a_d;
         det_b_q  <= det_b_d;
         stat_q   <= pins_s.status_change;
         pwr_q    <= pgood_s;
         pwr_en_q <= pwr_en_d;
      end
   end

   // hardware events from changes of the visible levels
   assign event_set = {
      pwr_q ^ pgood_s,
      det_b_q ^ det_b_d,
      det_a_q ^ det_a_d,
      stat_q ^ pins_s.status_change
   };

   // write one to clear, force loads, a hardware set wins
   always_comb begin
      event_d = event_q & ~(wr_event ? reg_wdata_in[3:0] : 4'h0);
      if (wr_force) begin
         event_d = f_events;
      end
      event_d = event_d | event_set;
   end

   assign mask_d = wr_mask ? reg_wdata_in[3:0] : mask_q;

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         event_q <= socket_status_force_pkg::EVENT_RESET;
         mask_q  <= socket_status_force_pkg::MASK_RESET;
      end else begin
         event_q <= event_d;
         mask_q  <= mask_d;
      end
   end

   // the state word; low live bits never see a force
   assign state_word = {
      socket_status_force_pkg::SOCK_CAP,
      14'h0000,
      card_q.volt,
      bad_q,
      loss_q,
      card_q.unknown,
      pins_s.ready_irq,
      card_q.wide,
      card_q.narrow,
      pwr_q,
      det_b_q,
      det_a_q,
      stat_q
   };

   // bit 0 uses the registered copy so it matches its event
   // read mux; force and unmapped words read zero
   always_comb begin
      rdata_d = socket_status_force_pkg::READ_ZERO;
      if (reg_rd_in & hit_state) begin
         rdata_d = state_word;
      end else if (reg_rd_in & hit_event) begin
         rdata_d = {28'h000_0000, event_q};
      end else if (reg_rd_in & hit_mask) begin
         rdata_d = {28'h000_0000, mask_q};
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_q <= socket_status_force_pkg::READ_ZERO;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // outputs
   assign reg_rdata_out     = rdata_q;
   assign power_ctrl_en_out = pwr_en_q;
   assign interrogating_out = ~idle;
   assign irq_out           = |(event_q & mask_q);

endmodule

//--- hw/socket_status_force_pkg.sv
package socket_status_force_pkg;

   // register offsets, byte addresses on the plain port
   localparam int         ADDR_W     = 8;
   localparam int         DATA_W     = 32;
   localparam logic [7:0] EVENT_OFS  = 8'h00;
   localparam logic [7:0] MASK_OFS   = 8'h04;
   localparam logic [7:0] STATE_OFS  = 8'h08;
   localparam logic [7:0] FORCE_OFS  = 8'h0c;

   // field positions in the state and force words
   localparam int SOCK_CAP_LSB   = 28;
   localparam int VOLT_LSB       = 10;
   localparam int BAD_SUPPLY_BIT = 9;
   localparam int LOSS_BIT       = 8;
   localparam int UNKNOWN_BIT    = 7;
   localparam int READY_BIT      = 6;
   localparam int WIDE_BIT       = 5;
   localparam int NARROW_BIT     = 4;
   localparam int POWERED_BIT    = 3;
   localparam int DETECT_B_BIT   = 2;
   localparam int DETECT_A_BIT   = 1;
   localparam int STATUS_BIT     = 0;
   localparam int REINTERROG_BIT = 14;
   localparam int EVENT_W        = 4;

   // socket supply capability, bits 31..28: only 3.3 V and 5 V
   localparam logic [3:0] SOCK_CAP = 4'h3;

   // reset values
   localparam logic [3:0]  EVENT_RESET = 4'h0;
   localparam logic [3:0]  MASK_RESET  = 4'h0;
   localparam logic [31:0] READ_ZERO   = 32'h0000_0000;
   localparam logic        PWR_EN_RST  = 1'b1;

   // interrogation time
   localparam int CLK_NS        = 5;
   localparam int INTERROG_NS   = 1000;
   localparam int INTERROG_CYC  = (INTERROG_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W         = 8;

   // live card-interface pins
   typedef struct packed {
      logic ready_irq;
      logic detect_b;
      logic detect_a;
      logic status_change;
   } socket_pins_s;

   // card identity as sensed during interrogation
   typedef struct packed {
      logic [3:0] volt;
      logic       unknown;
      logic       wide;
      logic       narrow;
   } card_id_s;

   localparam card_id_s CARD_ID_RESET = '0;

   // interrogation sequencer
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_PROBE = 2'b01,
      ST_LATCH = 2'b11
   } interrog_e;

endpackage

//--- test/socket_status_force_checker.sv
`timescale 1ns/10ps
module socket_status_force_checker (
   input wire logic                                  clk_sys_in,
   input wire logic                                  rst_b_in,
   input wire logic [7:0]                            reg_addr_in,
   input wire logic [31:0]                           reg_wdata_in,
   input wire logic                                  reg_wr_in,
   input wire logic                                  reg_rd_in,
   input wire logic [31:0]                           reg_rdata_out,
   input wire socket_status_force_pkg::socket_pins_s pins_in,
   input wire logic                                  power_ctrl_en_out,
   input wire logic                                  interrogating_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   // strobe decode for the force and state words
   wire        frc_wr = reg_wr_in && reg_addr_in == 8'h0c;
   wire        frc_rd = reg_rd_in && reg_addr_in == 8'h0c;
   wire        st_rd  = reg_rd_in && reg_addr_in == 8'h08;
   logic [9:0] frc_q;
   // last forced pattern, so a later read can be judged
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) frc_q <= '0;
      else if (frc_wr) frc_q <= reg_wdata_in[13:4];
   end
   AST_IDLE_ZERO: assert property (!$past(reg_rd_in) |->
      reg_rdata_out == 32'h0000_0000) else $error("data outside slot");
   AST_FORCE_READ: assert property (frc_rd |=>
      reg_rdata_out == 32'h0000_0000) else $error("force read not zero");
   AST_READY_LIVE: assert property ($stable(pins_in)[*5] ##0 st_rd |=>
      reg_rdata_out[6] == $past(pins_in.ready_irq)) else $error("ready bit");
   AST_STATUS_LIVE: assert property ($stable(pins_in)[*5]
      ##0 st_rd |=> reg_rdata_out[0] == $past(pins_in.status_change))
      else $error("status bit");
   // pulse-driven bits 9 and 8 left out: hardware may win there
   AST_FORCE_LOAD: assert property (frc_wr && !reg_wdata_in[14]
      && !interrogating_out ##2 st_rd |=>
      ((reg_rdata_out[13:4] ^ frc_q) & 10'h3cb) == 10'h000)
      else $error("forced state bits");
   AST_PWR_CTRL_OFF: assert property (frc_wr
      && |reg_wdata_in[13:10] |=> !power_ctrl_en_out)
      else $error("power control not disabled");
   AST_PWR_CTRL_ON: assert property ($rose(power_ctrl_en_out) |->
      $fell(interrogating_out)) else $error("enable outside latch");
   AST_PROBE_LEN: assert property (frc_wr && reg_wdata_in[14] |=>
      interrogating_out [*8] ##193 interrogating_out ##1 !interrogating_out)
      else $error("interrogation length");
endmodule

bind socket_status_force_regs socket_status_force_checker chk_i (
   .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .pins_in(pins_in),
   .power_ctrl_en_out(power_ctrl_en_out),
   .interrogating_out(interrogating_out));

//--- test/card_model.sv
`timescale 1ns/10ps
module card_model (
   input  wire logic                              inserted_in,
   input  wire socket_status_force_pkg::card_id_s id_in,
   input  wire logic                              ready_in,
   input  wire logic                              status_in,
   output socket_status_force_pkg::socket_pins_s  pins_out,
   output socket_status_force_pkg::card_id_s      card_id_out
);
   // socket pull-ups: an empty slot reads every pin high
   assign pins_out.detect_a      = !inserted_in;
   assign pins_out.detect_b      = !inserted_in;
   assign pins_out.ready_irq     = inserted_in ? ready_in : 1'b1;
   assign pins_out.status_change = inserted_in ? status_in : 1'b1;
   // no card, no sense result: show the inverse, never a stale id
   assign card_id_out = inserted_in ? id_in : ~id_in;
endmodule

//--- test/socket_status_force_regs_tb_top.sv
`timescale 1ns/10ps
module socket_status_force_regs_tb_top;
   logic clk = 0, rst_b = 0, wr, rd, pg, bad, loss, ins, rdy, sts;
   logic pce, prob, irq;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, d;
   int          failures = 0, total_checks = 0, cycles = 0;
   socket_status_force_pkg::card_id_s     id, cid;
   socket_status_force_pkg::socket_pins_s pins;
   always #2.5 clk = ~clk;
   card_model card (.inserted_in(ins), .id_in(id), .ready_in(rdy),
      .status_in(sts), .pins_out(pins), .card_id_out(cid));
   socket_status_force_regs uut (.clk_sys_in(clk), .rst_b_in(rst_b),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .pins_in(pins),
      .card_id_in(cid), .power_good_in(pg), .bad_supply_req_in(bad),
      .data_loss_in(loss), .power_ctrl_en_out(pce),
      .interrogating_out(prob), .irq_out(irq));
   task stop_test;
      if (failures == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a; wdata <= v; wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a; rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 d = rdata;
   endtask
   function automatic logic [31:0] st(input logic [3:0] v, input logic [2:0] b,
      input logic r, input logic [1:0] t, input logic p, input logic [1:0] c,
      input logic s);
      return {4'h3, 14'h0, v, b, r, t, p, c, s};
   endfunction
   // bounded wait on the interrogation flag
   task wait_prob(input logic v);
      int n;
      // look off the edge, once the flag has settled
      for (n = 0; n < 400 && prob !== v; n++) begin
         @(posedge clk);
         #1;
      end
      chk("interrogating", {31'h0, v}, {31'h0, prob});
   endtask
   task t_force;
      rd_reg(8'h0c); chk("force read", 0, d);
      rd_reg(8'h40); chk("unmapped read", 0, d);
      wr_reg(8'h0c, 32'hffff_bff0);
      #1 chk("power ctrl", 0, {31'h0, pce});
      rd_reg(8'h0c); chk("force reserved", 0, d);
      rd_reg(8'h08); chk("state", st(4'hf, 3'h7, 1, 3, 0, 3, 1), d);
      wr_reg(8'h0c, 32'h0000_0000);
      @(posedge clk); bad <= 1; loss <= 1;
      @(posedge clk); bad <= 0; loss <= 0;
      rd_reg(8'h08); chk("state", st(4'h0, 3'h6, 1, 0, 0, 3, 1), d);
      wr_reg(8'h0c, 32'h0000_0200);
      rd_reg(8'h08); chk("state", st(4'h0, 3'h4, 1, 0, 0, 3, 1), d);
      wr_reg(8'h00, 32'h0000_000f);
      for (int i = 0; i < 4; i++) begin
         wr_reg(8'h0c, 32'h1 << i);
         rd_reg(8'h08); chk("state low", 32'h7, {28'h0, d[3:0]});
         rd_reg(8'h00); chk("event", 32'h1 << i, d);
         chk("irq masked", 0, {31'h0, irq});
         wr_reg(8'h04, 32'h1 << i);
         #1 chk("irq", 1, {31'h0, irq});
         wr_reg(8'h00, 32'h1 << i);
         #1 chk("irq cleared", 0, {31'h0, irq});
         wr_reg(8'h04, 32'h0);
      end
   endtask
   task t_probe;
      @(posedge clk); ins <= 1; rdy <= 1; sts <= 1; id <= 7'h1a;
      wait_prob(1);
      // pull the card mid-probe: detect bits must hold the insert level
      @(posedge clk);
      ins <= 0;
      repeat (4) @(posedge clk);
      rd_reg(8'h08); chk("frozen", st(0, 0, 1, 0, 0, 0, 1), d);
      @(posedge clk);
      ins <= 1;
      wait_prob(0);
      chk("power ctrl", 1, {31'h0, pce});
      rd_reg(8'h08); chk("card id", st(3, 0, 1, 2, 0, 0, 1), d);
      @(posedge clk); id <= 7'h05;
      repeat (5) @(posedge clk);
      rd_reg(8'h08); chk("held id", st(3, 0, 1, 2, 0, 0, 1), d);
      wr_reg(8'h0c, 32'h0000_4000);
      #1 chk("started", 1, {31'h0, prob});
      wait_prob(0);
      rd_reg(8'h08); chk("new id", st(0, 1, 1, 1, 0, 0, 1), d);
   endtask
   task t_live;
      for (int i = 1; i >= 0; i--) begin
         @(posedge clk); rdy <= i[0]; sts <= !i[0]; pg <= i[0];
         repeat (4) @(posedge clk);
         rd_reg(8'h08);
         chk("live", {i[0], i[0], !i[0]}, {d[6], d[3], d[0]});
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         stop_test();
      end
   end
   initial begin
      {addr, wdata, wr, rd, pg, bad, loss, ins, rdy, sts} <= '0;
      id <= '0;
      repeat (20) @(posedge clk);
      rst_b <= 1;
      t_force();
      t_probe();
      t_live();
      stop_test();
   end
endmodule
